//--- rtl/chan_status_pkg.sv
package chan_status_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CMD_SLOTS = 100;
    localparam int unsigned CMD_IDX_W = 7;
    localparam int unsigned SLAVE_ADDR_W = 4;

    // word offsets of the status block
    localparam logic [15:0] CH3_PRESENT_FAULT_CODE_OFS = 16'h0030;
    localparam logic [15:0] CH3_PREVIOUS_FAULT_CODE_OFS = 16'h0031;
    localparam logic [15:0] CH4_TOP_STATE_OFS = 16'h0032;
    localparam logic [15:0] CH4_LINK_STATE_OFS = 16'h0033;
    localparam logic [15:0] CH4_SLAVE_FAULT_MAP_OFS = 16'h0034;
    localparam logic [15:0] CH4_SLAVE_POLL_MAP_OFS = 16'h0035;
    localparam logic [15:0] CH4_SLAVE_LONGADDR_MAP_OFS = 16'h0036;
    localparam logic [15:0] CH4_ACTIVE_CMD_INDEX_OFS = 16'h0037;
    localparam logic [15:0] CH4_REQUESTS_SENT_OFS = 16'h0038;
    localparam logic [15:0] CH4_RESPONSES_SEEN_OFS = 16'h0039;
    localparam logic [15:0] CH4_SETUP_FAULT_FLAGS_OFS = 16'h003A;
    localparam logic [15:0] CH4_PRESENT_FAULT_CODE_OFS = 16'h003B;
    localparam logic [15:0] CH4_PREVIOUS_FAULT_CODE_OFS = 16'h003C;
    localparam logic [15:0] STATUS_BLOCK_TAG_OFS = 16'h00F9;
    localparam logic [15:0] CMD_FAULT_BASE_OFS = 16'h00FA;

    // reset values
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] CMD_FAULT_BASE_RESET = 16'h0100;
    localparam logic [15:0] STATUS_BLOCK_TAG_RESET = 16'h0000;

    // command status word layout
    localparam int unsigned STAT_COMM_BIT = 15;
    localparam logic [15:0] TIMEOUT_WORD = 16'hFFFF;

    // setup fault bit positions
    localparam int unsigned CFG_ENABLE_BIT = 0;
    localparam int unsigned CFG_HANDHELD_BIT = 1;
    localparam int unsigned CFG_PRIMARY_BIT = 2;
    localparam int unsigned CFG_PREAMBLE_BIT = 3;
    localparam int unsigned CFG_SHORT_RETRY_BIT = 4;
    localparam int unsigned CFG_LONG_RETRY_BIT = 5;
    localparam int unsigned CFG_ERR_RETRY_BIT = 6;
    localparam int unsigned CFG_ERR_POLL_BIT = 7;
    localparam int unsigned CFG_DB_ADDR_BIT = 8;
    localparam int unsigned CFG_CMD_COUNT_BIT = 9;
    localparam int unsigned CFG_ALLOC_CMD_BIT = 10;
    localparam int unsigned CFG_ALLOC_FIXED_BIT = 11;
    localparam int unsigned CFG_ALLOC_BUF_BIT = 12;
    localparam int unsigned CFG_BOARD_BIT = 13;
    localparam int unsigned CFG_INIT_BIT = 14;

    // setting limits
    localparam logic [15:0] PREAMBLE_MIN = 16'h0001;
    localparam logic [15:0] PREAMBLE_MAX = 16'h0032;
    localparam logic [15:0] RETRY_MAX = 16'h0032;
    localparam logic [15:0] ERR_POLL_MAX = 16'h2710;
    localparam logic [7:0] CHAR_YES = 8'h59;
    localparam logic [7:0] CHAR_NO = 8'h4E;

    typedef enum logic [2:0] {
        top_polling = 3'h0,
        top_configuring = 3'h1,
        top_data_poll = 3'h2,
        top_user_poll = 3'h3,
        await_identifier_state = 3'h4
    } top_state_t;

    typedef enum logic [2:0] {
        link_startup = 3'h0,
        link_idle = 3'h1,
        link_tx_pending = 3'h2,
        link_transmit = 3'h3,
        link_receive = 3'h4,
        link_post_tx = 3'h5,
        link_idle_waiting = 3'h6
    } link_state_t;

endpackage : chan_status_pkg

//--- rtl/setup_fault_check.sv
`timescale 1ns/1ps
module setup_fault_check #(
    parameter logic [15:0] DB_WORDS = 16'h0FA0,
    parameter logic [15:0] CMD_MAX = 16'h0064
) (
    input wire logic [7:0] ENABLE_CHAR,
    input wire logic [7:0] HANDHELD_CHAR,
    input wire logic [7:0] PRIMARY_CHAR,
    input wire logic [15:0] PREAMBLES,
    input wire logic [15:0] SHORT_RETRIES,
    input wire logic [15:0] LONG_RETRIES,
    input wire logic [15:0] ERR_RETRIES,
    input wire logic [15:0] ERR_POLL_TIME,
    input wire logic [15:0] DB_STATUS_ADDR,
    input wire logic [15:0] CMD_COUNT,
    input wire logic [4:0] HW_FAULTS,
    output logic [15:0] FLAGS
);
    function automatic logic not_yes_no(input logic [7:0] c);
        not_yes_no = (c != chan_status_pkg::CHAR_YES) && (c != chan_status_pkg::CHAR_NO);
    endfunction : not_yes_no

    always_comb begin
        FLAGS = chan_status_pkg::WORD_RESET;
        FLAGS[chan_status_pkg::CFG_ENABLE_BIT] = not_yes_no(ENABLE_CHAR);
        FLAGS[chan_status_pkg::CFG_HANDHELD_BIT] = not_yes_no(HANDHELD_CHAR);
        FLAGS[chan_status_pkg::CFG_PRIMARY_BIT] = not_yes_no(PRIMARY_CHAR);
        FLAGS[chan_status_pkg::CFG_PREAMBLE_BIT] = (PREAMBLES < chan_status_pkg::PREAMBLE_MIN)
            || (PREAMBLES > chan_status_pkg::PREAMBLE_MAX);
        FLAGS[chan_status_pkg::CFG_SHORT_RETRY_BIT] = SHORT_RETRIES > chan_status_pkg::RETRY_MAX;
        FLAGS[chan_status_pkg::CFG_LONG_RETRY_BIT] = LONG_RETRIES > chan_status_pkg::RETRY_MAX;
        FLAGS[chan_status_pkg::CFG_ERR_RETRY_BIT] = ERR_RETRIES > chan_status_pkg::RETRY_MAX;
        FLAGS[chan_status_pkg::CFG_ERR_POLL_BIT] = ERR_POLL_TIME > chan_status_pkg::ERR_POLL_MAX;
        FLAGS[chan_status_pkg::CFG_DB_ADDR_BIT] = DB_STATUS_ADDR >= DB_WORDS;
        FLAGS[chan_status_pkg::CFG_CMD_COUNT_BIT] = CMD_COUNT > CMD_MAX;
        // memory, board and init failures in bits 10 to 14; bit 15 stays clear
        FLAGS[chan_status_pkg::CFG_INIT_BIT:chan_status_pkg::CFG_ALLOC_CMD_BIT] = HW_FAULTS;
    end

endmodule : setup_fault_check

//--- rtl/cmd_fault_store.sv
`timescale 1ns/1ps
module cmd_fault_store #(
    parameter int unsigned SLOTS = 100,
    parameter int unsigned IDX_W = 7
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic WR_EN,
    input wire logic [IDX_W-1:0] WR_IDX,
    input wire logic [15:0] WR_DATA,
    input wire logic [IDX_W-1:0] RD_IDX,
    output logic [15:0] RD_DATA
);
    typedef struct packed {
        logic [SLOTS-1:0][15:0] words;
    } store_t;

    store_t st_r;
    store_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (WR_EN && (32'(WR_IDX) < SLOTS)) begin
            st_nxt.words[WR_IDX] = WR_DATA;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign RD_DATA = (32'(RD_IDX) < SLOTS) ? st_r.words[RD_IDX] : chan_status_pkg::WORD_RESET;

endmodule : cmd_fault_store

//--- rtl/channel_status_error_report.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// Behaviour
// RL1 - slave fault bitmap, bit n per address; address 0 is ignored and bit 0 held clear
// RL2 - poll membership bitmap, bit zero unused
// RL3 - long address bitmap, bit zero unused
// RL4 - expose channel top state, five values
// RL5 - top states encoded zero through four
// RL6 - expose link state, seven values
// RL7 - active command index, request and response counts
// RL8 - present and previous fault code words
// RL9 - reserved words zero; tag word marks status
// RL10 - one setup fault word per channel
// RL11 - bits 0-2 flag invalid yes/no settings
// RL12 - bits 3-7 flag out-of-range settings
// RL13 - bit 8 database address, bit 9 count
// RL14 - bits 10-12 flag storage allocation failures
// RL15 - bit 13 board absent, 14 init fail
// RL16 - one fault word per command, 0-99
// RL17 - command fault list at configurable base
// RL18 - status word leads returned data block
// RL19 - comm error: top bit, code high, low zero
// RL20 - otherwise command code high, malfunction low
// RL21 - timeout writes 0xFFFF status word
// RL22 - request and response counters wrap around
module channel_status_error_report #(
    parameter logic [15:0] BLOCK_TAG = chan_status_pkg::STATUS_BLOCK_TAG_RESET,
    parameter logic [15:0] DB_WORDS = 16'h0FA0
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic [15:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic [2:0] TOP_STATE,
    input wire logic [2:0] LINK_STATE,
    input wire logic [3:0] SLAVE_ADDR,
    input wire logic FAULT_WE,
    input wire logic FAULT_VAL,
    input wire logic POLL_WE,
    input wire logic POLL_VAL,
    input wire logic LONG_WE,
    input wire logic LONG_VAL,
    input wire logic [6:0] ACTIVE_CMD,
    input wire logic REQ_SENT,
    input wire logic RESP_SEEN,
    input wire logic ERR_REPORT,
    input wire logic [15:0] ERR_CODE,
    input wire logic CH3_ERR_REPORT,
    input wire logic [15:0] CH3_ERR_CODE,
    input wire logic CFG_LOAD,
    input wire logic [7:0] CFG_ENABLE_CHAR,
    input wire logic [7:0] CFG_HANDHELD_CHAR,
    input wire logic [7:0] CFG_PRIMARY_CHAR,
    input wire logic [15:0] CFG_PREAMBLES,
    input wire logic [15:0] CFG_SHORT_RETRIES,
    input wire logic [15:0] CFG_LONG_RETRIES,
    input wire logic [15:0] CFG_ERR_RETRIES,
    input wire logic [15:0] CFG_ERR_POLL_TIME,
    input wire logic [15:0] CFG_DB_STATUS_ADDR,
    input wire logic [15:0] CFG_CMD_COUNT,
    input wire logic ALLOC_CMD_FAIL,
    input wire logic ALLOC_FIXED_FAIL,
    input wire logic ALLOC_BUF_FAIL,
    input wire logic BOARD_ABSENT,
    input wire logic INIT_FAIL,
    input wire logic CMD_DONE,
    input wire logic [6:0] CMD_IDX,
    input wire logic CMD_TIMEOUT,
    input wire logic CMD_COMM_ERR,
    input wire logic [6:0] COMM_CODE,
    input wire logic [6:0] CMD_ERR_CODE,
    input wire logic [7:0] DEV_STATUS,
    output logic [15:0] STATUS_WORD,
    output logic STATUS_VALID
);

    typedef struct packed {
        logic [15:0] rdata;
        logic [15:0] status_word;
        logic status_valid;
        logic [15:0] ch3_present;
        logic [15:0] ch3_previous;
        logic [15:0] present;
        logic [15:0] previous;
        chan_status_pkg::top_state_t top;
        chan_status_pkg::link_state_t link;
        logic [15:0] fault_map;
        logic [15:0] poll_map;
        logic [15:0] long_map;
        logic [6:0] cur_cmd;
        logic [15:0] req_cnt;
        logic [15:0] resp_cnt;
        logic [15:0] setup_flags;
        logic [15:0] err_base;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [15:0] cfg_flags;
    logic [15:0] list_word;
    logic [15:0] list_ofs;
    logic in_list;
    logic [15:0] cmd_word;
    logic store_we;

    // bit zero never names a slave, so it is forced clear
    function automatic logic [15:0] map_update(
        input logic [15:0] map,
        input logic [3:0] slave,
        input logic we,
        input logic val
    );
        logic [15:0] m;
        m = map;
        if (we && (slave != 4'h0)) begin
            m[slave] = val;
        end
        m[0] = 1'b0;
        map_update = m;
    endfunction : map_update

    function automatic logic [15:0] format_status(
        input logic timeout,
        input logic comm_err,
        input logic [6:0] comm_code,
        input logic [6:0] cmd_code,
        input logic [7:0] dev_stat
    );
        if (timeout) begin
            format_status = chan_status_pkg::TIMEOUT_WORD; // see RL21
        end else if (comm_err) begin
            format_status = {1'b1, comm_code, 8'h00}; // see RL19
        end else begin
            format_status = {1'b0, cmd_code, dev_stat}; // see RL20
        end
    endfunction : format_status

    setup_fault_check #(
        .DB_WORDS(DB_WORDS),
        .CMD_MAX(16'(chan_status_pkg::CMD_SLOTS))
    ) u_check (
        .ENABLE_CHAR(CFG_ENABLE_CHAR),
        .HANDHELD_CHAR(CFG_HANDHELD_CHAR),
        .PRIMARY_CHAR(CFG_PRIMARY_CHAR),
        .PREAMBLES(CFG_PREAMBLES),
        .SHORT_RETRIES(CFG_SHORT_RETRIES),
        .LONG_RETRIES(CFG_LONG_RETRIES),
        .ERR_RETRIES(CFG_ERR_RETRIES),
        .ERR_POLL_TIME(CFG_ERR_POLL_TIME),
        .DB_STATUS_ADDR(CFG_DB_STATUS_ADDR),
        .CMD_COUNT(CFG_CMD_COUNT),
        .HW_FAULTS({INIT_FAIL, BOARD_ABSENT, ALLOC_BUF_FAIL, ALLOC_FIXED_FAIL, ALLOC_CMD_FAIL}),
        .FLAGS(cfg_flags)
    );

    // command fault list lives at a software-set base
    assign list_ofs = ADDR - st_r.err_base; // see RL17
    assign in_list = (ADDR >= st_r.err_base)
        && (list_ofs < 16'(chan_status_pkg::CMD_SLOTS)); // see RL16
    assign cmd_word = format_status(CMD_TIMEOUT, CMD_COMM_ERR, COMM_CODE, CMD_ERR_CODE,
        DEV_STATUS);
    assign store_we = CMD_DONE;

    cmd_fault_store #(
        .SLOTS(chan_status_pkg::CMD_SLOTS),
        .IDX_W(chan_status_pkg::CMD_IDX_W)
    ) u_store (
        .CORE_CLK(CORE_CLK),
        .RESET_N(RESET_N),
        .WR_EN(store_we),
        .WR_IDX(CMD_IDX),
        .WR_DATA(cmd_word),
        .RD_IDX(list_ofs[6:0]),
        .RD_DATA(list_word)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.status_valid = 1'b0;
        st_nxt.fault_map = map_update(st_r.fault_map, SLAVE_ADDR, FAULT_WE, FAULT_VAL); // see RL1
        st_nxt.poll_map = map_update(st_r.poll_map, SLAVE_ADDR, POLL_WE, POLL_VAL); // see RL2
        st_nxt.long_map = map_update(st_r.long_map, SLAVE_ADDR, LONG_WE, LONG_VAL); // see RL3
        // an undefined code on the input keeps the last legal state
        if (TOP_STATE <= 3'(chan_status_pkg::await_identifier_state)) begin
            st_nxt.top = chan_status_pkg::top_state_t'(TOP_STATE); // see RL4 RL5
        end
        if (LINK_STATE <= 3'(chan_status_pkg::link_idle_waiting)) begin
            st_nxt.link = chan_status_pkg::link_state_t'(LINK_STATE); // see RL6
        end
        st_nxt.cur_cmd = ACTIVE_CMD; // see RL7
        if (REQ_SENT) begin
            st_nxt.req_cnt = st_r.req_cnt + 16'h0001; // see RL7 RL22
        end
        if (RESP_SEEN) begin
            st_nxt.resp_cnt = st_r.resp_cnt + 16'h0001; // see RL7 RL22
        end
        if (ERR_REPORT) begin
            st_nxt.previous = st_r.present; // see RL8
            st_nxt.present = ERR_CODE;
        end
        if (CH3_ERR_REPORT) begin
            st_nxt.ch3_previous = st_r.ch3_present; // see RL8
            st_nxt.ch3_present = CH3_ERR_CODE;
        end
        if (CFG_LOAD) begin
            st_nxt.setup_flags = cfg_flags; // see RL10 RL11 RL12 RL13 RL14 RL15
        end
        if (CMD_DONE) begin
            st_nxt.status_word = cmd_word; // see RL18
            st_nxt.status_valid = 1'b1;
        end
        if (WR && (ADDR == chan_status_pkg::CMD_FAULT_BASE_OFS)) begin
            st_nxt.err_base = WDATA; // see RL17
        end
        st_nxt.rdata = chan_status_pkg::WORD_RESET;
        if (RD) begin
            unique case (ADDR)
                chan_status_pkg::CH3_PRESENT_FAULT_CODE_OFS: begin
                    st_nxt.rdata = st_r.ch3_present;
                end
                chan_status_pkg::CH3_PREVIOUS_FAULT_CODE_OFS: begin
                    st_nxt.rdata = st_r.ch3_previous;
                end
                chan_status_pkg::CH4_TOP_STATE_OFS: begin
                    st_nxt.rdata = {13'h0000, st_r.top};
                end
                chan_status_pkg::CH4_LINK_STATE_OFS: begin
                    st_nxt.rdata = {13'h0000, st_r.link};
                end
                chan_status_pkg::CH4_SLAVE_FAULT_MAP_OFS: begin
                    st_nxt.rdata = st_r.fault_map;
                end
                chan_status_pkg::CH4_SLAVE_POLL_MAP_OFS: begin
                    st_nxt.rdata = st_r.poll_map;
                end
                chan_status_pkg::CH4_SLAVE_LONGADDR_MAP_OFS: begin
                    st_nxt.rdata = st_r.long_map;
                end
                chan_status_pkg::CH4_ACTIVE_CMD_INDEX_OFS: begin
                    st_nxt.rdata = {9'h000, st_r.cur_cmd};
                end
                chan_status_pkg::CH4_REQUESTS_SENT_OFS: begin
                    st_nxt.rdata = st_r.req_cnt;
                end
                chan_status_pkg::CH4_RESPONSES_SEEN_OFS: begin
                    st_nxt.rdata = st_r.resp_cnt;
                end
                chan_status_pkg::CH4_SETUP_FAULT_FLAGS_OFS: begin
                    st_nxt.rdata = st_r.setup_flags;
                end
                chan_status_pkg::CH4_PRESENT_FAULT_CODE_OFS: begin
                    st_nxt.rdata = st_r.present;
                end
                chan_status_pkg::CH4_PREVIOUS_FAULT_CODE_OFS: begin
                    st_nxt.rdata = st_r.previous;
                end
                chan_status_pkg::STATUS_BLOCK_TAG_OFS: begin
                    st_nxt.rdata = BLOCK_TAG; // see RL9
                end
                chan_status_pkg::CMD_FAULT_BASE_OFS: begin
                    st_nxt.rdata = st_r.err_base;
                end
                default: begin
                    // reserved words read zero unless the fault list sits there
                    st_nxt.rdata = in_list ? list_word : chan_status_pkg::WORD_RESET; // see RL9 RL16
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r <= '0;
            st_r.err_base <= chan_status_pkg::CMD_FAULT_BASE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign RDATA = st_r.rdata;
    assign STATUS_WORD = st_r.status_word;
    assign STATUS_VALID = st_r.status_valid;

    a_fault_map_update: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RL1
        FAULT_WE && (SLAVE_ADDR != 4'h0) |=> st_r.fault_map[$past(SLAVE_ADDR)] == $past(FAULT_VAL))
        else $error("slave fault bit not updated");

    a_map_bit_zero: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RL2
        !st_r.fault_map[0] && !st_r.poll_map[0] && !st_r.long_map[0])
        else $error("bitmap bit zero set");

    a_long_map_update: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RL3
        LONG_WE && (SLAVE_ADDR != 4'h0) ##1 !LONG_WE [*2]
        |-> st_r.long_map[$past(SLAVE_ADDR, 2)] == $past(LONG_VAL, 2))
        else $error("long address bit lost");

    a_top_state_code: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RL5
        RD && (ADDR == chan_status_pkg::CH4_TOP_STATE_OFS) && (TOP_STATE == 3'h4)
        && ($past(TOP_STATE) == 3'h4) |=> RDATA == 16'h0004)
        else $error("top state encoding wrong");

    a_link_state_hold: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RL6
        LINK_STATE > 3'h6 |=> st_r.link == $past(st_r.link))
        else $error("illegal link code taken");

    a_req_count_wrap: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RL22
        REQ_SENT && (st_r.req_cnt == 16'hFFFF) |=> st_r.req_cnt == 16'h0000)
        else $error("request counter did not wrap");

    a_resp_count_step: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RL7
        RESP_SEEN |=> st_r.resp_cnt == 16'($past(st_r.resp_cnt) + 16'h0001))
        else $error("response counter step wrong");

    a_previous_code: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RL8
        ERR_REPORT |=> (st_r.previous == $past(st_r.present)) && (st_r.present == $past(ERR_CODE)))
        else $error("fault code history wrong");

    a_tag_read: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RL9
        RD && (ADDR == chan_status_pkg::STATUS_BLOCK_TAG_OFS) |=> RDATA == BLOCK_TAG)
        else $error("block tag read wrong");

    a_flag_bit15_clear: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RL15
        CFG_LOAD |=> !st_r.setup_flags[15]
        && (st_r.setup_flags[13] == $past(BOARD_ABSENT)))
        else $error("setup flag bits wrong");

    a_timeout_word: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RL21
        CMD_DONE && CMD_TIMEOUT |=> STATUS_VALID && (STATUS_WORD == 16'hFFFF))
        else $error("timeout word missing");

    a_comm_format: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RL19
        CMD_DONE && !CMD_TIMEOUT && CMD_COMM_ERR
        |=> STATUS_WORD[15] && (STATUS_WORD[7:0] == 8'h00))
        else $error("comm error word malformed");

    a_list_readback: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see RL16
        CMD_DONE && (CMD_IDX == 7'h00) && !WR ##1 RD && (ADDR == st_r.err_base) && !CMD_DONE
        |=> RDATA == $past(STATUS_WORD))
        else $error("fault list readback wrong");

endmodule : channel_status_error_report

//--- dv/field_slave_model.sv
`timescale 1ns/1ps
module field_slave_model (
    input wire logic CORE_CLK,
    input wire logic GO,
    input wire logic [1:0] MODE,
    output logic REQ_SENT = '0,
    output logic RESP_SEEN = '0,
    output logic CMD_DONE = '0,
    output logic CMD_TIMEOUT = '0,
    output logic CMD_COMM_ERR = '0,
    output logic [6:0] COMM_CODE = '0,
    output logic [6:0] CMD_ERR_CODE = '0,
    output logic [7:0] DEV_STATUS = '0
);
    logic pend = '0;
    logic [1:0] mode_r = '0;
    always @(posedge CORE_CLK) begin
        REQ_SENT <= GO;
        pend <= GO;
        mode_r <= MODE;
        CMD_DONE <= pend;
        // mode 2 is a slave that stays silent past its timeout
        RESP_SEEN <= pend && mode_r != 2'h2;
        CMD_TIMEOUT <= pend && mode_r == 2'h2;
        CMD_COMM_ERR <= pend && mode_r == 2'h1;
        // qualifiers mean nothing between completions, so they toggle
        COMM_CODE <= pend ? 7'h29 : ~COMM_CODE;
        CMD_ERR_CODE <= pend ? 7'h10 : ~CMD_ERR_CODE;
        DEV_STATUS <= pend ? 8'h84 : ~DEV_STATUS;
    end
endmodule : field_slave_model

//--- dv/channel_status_error_report_tb.sv
`timescale 1ns/1ps
module channel_status_error_report_tb;
    logic CORE_CLK = '0, RESET_N = '0, WR = '0, RD = '0, GO = '0, CFG_LOAD = '0;
    logic FAULT_WE = '0, FAULT_VAL = '0, POLL_WE = '0, POLL_VAL = '0, LONG_WE = '0;
    logic LONG_VAL = '0, ERR_REPORT = '0, CH3_ERR_REPORT = '0, ALLOC_CMD_FAIL = '0;
    logic ALLOC_FIXED_FAIL = '0, ALLOC_BUF_FAIL = '0, BOARD_ABSENT = '0, INIT_FAIL = '0;
    logic [15:0] ADDR = '0, WDATA = '0, ERR_CODE = '0, CH3_ERR_CODE = '0, RDATA, STATUS_WORD;
    logic [15:0] CFG_PREAMBLES = '0, CFG_SHORT_RETRIES = '0, CFG_LONG_RETRIES = '0;
    logic [15:0] CFG_ERR_RETRIES = '0, CFG_ERR_POLL_TIME = '0, CFG_DB_STATUS_ADDR = '0;
    logic [15:0] CFG_CMD_COUNT = '0;
    logic [7:0] CFG_ENABLE_CHAR = '0, CFG_HANDHELD_CHAR = '0, CFG_PRIMARY_CHAR = '0;
    logic [2:0] TOP_STATE = '0, LINK_STATE = '0;
    logic [3:0] SLAVE_ADDR = '0;
    logic [6:0] ACTIVE_CMD = '0, CMD_IDX = '0, COMM_CODE, CMD_ERR_CODE;
    logic [1:0] MODE = '0;
    logic [7:0] DEV_STATUS;
    logic STATUS_VALID, REQ_SENT, RESP_SEEN, CMD_DONE, CMD_TIMEOUT, CMD_COMM_ERR;
    int miscompares = 0, n_compared = 0, cycles = 0;

    channel_status_error_report uut (.*);
    field_slave_model slaves (.*);

    initial begin
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    task automatic summarize;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge CORE_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CORE_CLK);
        WR <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge CORE_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CORE_CLK);
        RD <= 1'b0;
        #1 chk(RDATA, exp);
        @(posedge CORE_CLK);
        #1 chk(RDATA, 16'h0000);
    endtask : rd

    task automatic bm(input logic [2:0] sel, input logic [3:0] a, input logic v);
        @(posedge CORE_CLK);
        {FAULT_WE, POLL_WE, LONG_WE} <= sel;
        {FAULT_VAL, POLL_VAL, LONG_VAL} <= {3{v}};
        SLAVE_ADDR <= a;
        @(posedge CORE_CLK);
        {FAULT_WE, POLL_WE, LONG_WE} <= 3'h0;
    endtask : bm

    task automatic cmd(input logic [1:0] m, input logic [6:0] idx, input logic [15:0] exp);
        @(posedge CORE_CLK);
        MODE <= m;
        CMD_IDX <= idx;
        GO <= 1'b1;
        @(posedge CORE_CLK);
        GO <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        #1 chk({STATUS_VALID, STATUS_WORD[14:0]}, {1'b1, exp[14:0]});
        chk(STATUS_WORD, exp);
        @(posedge CORE_CLK);
        #1 chk({15'h0000, STATUS_VALID}, 16'h0000);
    endtask : cmd

    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 70000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        repeat (5) @(posedge CORE_CLK);
        RESET_N <= 1'b1;
        wr(16'h0034, 16'hFFFF);
        for (logic [15:0] a = 16'h0030; a < 16'h003E; a++) rd(a, 16'h0000);
        rd(16'h00F9, 16'h0000);
        rd(16'h00FA, 16'h0100);
        for (int i = 0; i < 8; i++) begin
            @(posedge CORE_CLK);
            TOP_STATE <= 3'(i);
            LINK_STATE <= 3'(i);
            rd(16'h0032, (i > 4) ? 16'h0004 : 16'(i));
            rd(16'h0033, (i > 6) ? 16'h0006 : 16'(i));
        end
        bm(3'h4, 4'h1, 1'b1);
        bm(3'h4, 4'hF, 1'b1);
        bm(3'h7, 4'h0, 1'b1);
        bm(3'h2, 4'h3, 1'b1);
        bm(3'h1, 4'h4, 1'b1);
        bm(3'h4, 4'h1, 1'b0);
        rd(16'h0034, 16'h8000);
        rd(16'h0035, 16'h0008);
        rd(16'h0036, 16'h0010);
        @(posedge CORE_CLK);
        ACTIVE_CMD <= 7'h63;
        {ERR_REPORT, CH3_ERR_REPORT, ERR_CODE, CH3_ERR_CODE} <= {2'h3, 32'h12340A0A};
        @(posedge CORE_CLK);
        {ERR_CODE, CH3_ERR_CODE} <= 32'h56780B0B;
        @(posedge CORE_CLK);
        {ERR_REPORT, CH3_ERR_REPORT} <= 2'h0;
        rd(16'h0037, 16'h0063);
        rd(16'h003B, 16'h5678);
        rd(16'h003C, 16'h1234);
        rd(16'h0030, 16'h0B0B);
        rd(16'h0031, 16'h0A0A);
        // one spoiled setting per pass, limits elsewhere; pass 15 is all valid
        for (int i = 0; i < 16; i++) begin
            @(posedge CORE_CLK);
            CFG_ENABLE_CHAR <= (i == 0) ? 8'h79 : 8'h59;
            CFG_HANDHELD_CHAR <= (i == 1) ? 8'h20 : 8'h4E;
            CFG_PRIMARY_CHAR <= (i == 2) ? 8'h6E : 8'h59;
            CFG_PREAMBLES <= (i == 3) ? 16'h0000 : 16'h0032;
            CFG_SHORT_RETRIES <= (i == 4) ? 16'h0033 : 16'h0032;
            CFG_LONG_RETRIES <= (i == 5) ? 16'h0033 : 16'h0000;
            CFG_ERR_RETRIES <= (i == 6) ? 16'hFFFF : 16'h0032;
            CFG_ERR_POLL_TIME <= (i == 7) ? 16'h2711 : 16'h2710;
            CFG_DB_STATUS_ADDR <= (i == 8) ? 16'h0FA0 : 16'h0F9F;
            CFG_CMD_COUNT <= (i == 9) ? 16'h0065 : 16'h0064;
            {INIT_FAIL, BOARD_ABSENT, ALLOC_BUF_FAIL, ALLOC_FIXED_FAIL, ALLOC_CMD_FAIL}
                <= (i > 9 && i < 15) ? 5'h01 << (i - 10) : 5'h00;
            CFG_LOAD <= 1'b1;
            @(posedge CORE_CLK);
            CFG_LOAD <= 1'b0;
            rd(16'h003A, (i == 15) ? 16'h0000 : 16'h0001 << i);
        end
        wr(16'h00FA, 16'h0200);
        rd(16'h00FA, 16'h0200);
        cmd(2'h2, 7'h00, 16'hFFFF);
        cmd(2'h1, 7'h63, 16'hA900);
        cmd(2'h0, 7'h05, 16'h1084);
        rd(16'h0200, 16'hFFFF);
        rd(16'h0263, 16'hA900);
        rd(16'h0205, 16'h1084);
        // read slot 0 in the cycle right after its completion
        @(posedge CORE_CLK);
        {MODE, CMD_IDX, GO} <= {2'h1, 7'h00, 1'b1};
        @(posedge CORE_CLK);
        GO <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        {ADDR, RD} <= {16'h0200, 1'b1};
        @(posedge CORE_CLK);
        RD <= 1'b0;
        #1 chk(RDATA, 16'hA900);
        rd(16'h0038, 16'h0004);
        rd(16'h0039, 16'h0003);
        @(posedge CORE_CLK);
        {MODE, CMD_IDX, GO} <= {2'h0, 7'h07, 1'b1};
        repeat (65536) @(posedge CORE_CLK);
        GO <= 1'b0;
        repeat (4) @(posedge CORE_CLK);
        rd(16'h0038, 16'h0004);
        rd(16'h0039, 16'h0003);
        summarize();
    end
endmodule : channel_status_error_report_tb
